// file: logic/scan_acquisition_sequencer.sv
// Scan acquisition sequencer: APB registers, channel queue, scan timing, sample FIFO.
// Assumes ADC_DONE/ADC_DATA come from logic on CLK; EXT_* pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module scan_acquisition_sequencer #(
  parameter int FIFO_DEPTH = 1024,
  parameter int QUEUE_DEPTH = 512
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Pins
  input wire logic EXT_TIMEBASE,
  input wire logic EXT_TRIGGER,
  output logic SIMULTANEOUS_HOLD_STROBE,
  // Converter
  output logic ADC_START,
  output acq_seq_pkg::queue_entry_t ADC_SELECT,
  input wire logic ADC_DONE,
  input wire logic [acq_seq_pkg::SAMPLE_W-1:0] ADC_DATA
);
  import acq_seq_pkg::*;

  localparam int FAW = $clog2(FIFO_DEPTH);
  localparam int QAW = $clog2(QUEUE_DEPTH);

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_PEND, ST_SCAN} acq_state_t;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic wr_en;
  logic rd_en;
  logic mapped;
  assign wr_en = PSEL & PENABLE & PWRITE;
  assign rd_en = PSEL & PENABLE & ~PWRITE;
  assign mapped = hit(PADDR, ADDR_SAMPLE_DATA) | hit(PADDR, ADDR_FIFO_COND) | hit(PADDR, ADDR_TRIG_SETUP)
    | hit(PADDR, ADDR_SCAN_INTERVAL) | hit(PADDR, ADDR_SAMPLE_INTERVAL) | hit(PADDR, ADDR_SCAN_TOTAL)
    | hit(PADDR, ADDR_SCAN_SAMPLES) | hit(PADDR, ADDR_QUEUE_DATA) | hit(PADDR, ADDR_QUEUE_CTRL);
  assign PREADY = PSEL & PENABLE;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  acq_state_t state;
  logic [10:0] trig_setup;
  logic [SCAN_INTERVAL_W-1:0] scan_interval;
  logic [SAMPLE_INTERVAL_W-1:0] sample_interval_count;
  logic [SCAN_TOTAL_W-1:0] scan_total_count;
  logic [SCAN_SAMPLES_W-1:0] scan_samples;
  logic soft_conv;
  assign soft_conv = wr_en & hit(PADDR, ADDR_TRIG_SETUP) & PWDATA[TRIG_SOFT_CONV_BIT] & (state == ST_IDLE);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      trig_setup <= '0;
      scan_interval <= SCAN_INTERVAL_RESET;
      sample_interval_count <= SAMPLE_INTERVAL_RESET;
      scan_total_count <= SCAN_TOTAL_RESET;
      scan_samples <= SCAN_SAMPLES_RESET;
    end else if (wr_en) begin
      if (hit(PADDR, ADDR_TRIG_SETUP)) trig_setup <= PWDATA[10:0] & TRIG_SETUP_MASK;
      if (hit(PADDR, ADDR_SCAN_INTERVAL)) scan_interval <= PWDATA[SCAN_INTERVAL_W-1:0];
      if (hit(PADDR, ADDR_SAMPLE_INTERVAL)) sample_interval_count <= PWDATA[SAMPLE_INTERVAL_W-1:0];
      if (hit(PADDR, ADDR_SCAN_TOTAL)) scan_total_count <= PWDATA[SCAN_TOTAL_W-1:0];
      if (hit(PADDR, ADDR_SCAN_SAMPLES)) scan_samples <= PWDATA[SCAN_SAMPLES_W-1:0];
    end
  end

  logic acq_en;
  logic tb_external;
  logic trig_negative;
  trig_mode_t trig_mode;
  assign acq_en = trig_setup[TRIG_ACQ_EN_BIT];
  assign tb_external = trig_setup[TRIG_TIMEBASE_BIT];
  assign trig_negative = trig_setup[TRIG_POLARITY_BIT];
  assign trig_mode = trig_mode_t'(trig_setup[TRIG_MODE_LSB +: 3]);

  // ----------------------------------------
  // Pin synchronisers and timebase
  // ----------------------------------------
  logic [2:0] tb_sync;
  logic [2:0] trg_sync;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      tb_sync <= '0;
      trg_sync <= '0;
    end else begin
      tb_sync <= {tb_sync[1:0], EXT_TIMEBASE};
      trg_sync <= {trg_sync[1:0], EXT_TRIGGER};
    end
  end

  // Fractional accumulator: 24 ticks per 125 clocks, jitter of one clock
  logic [7:0] tb_acc;
  logic [7:0] next_tb_acc;
  logic int_tick;
  always_comb begin
    next_tb_acc = tb_acc + 8'(INT_TIMEBASE_MHZ);
    int_tick = next_tb_acc >= 8'(CLK_MHZ);
    if (int_tick) next_tb_acc = next_tb_acc - 8'(CLK_MHZ);
  end
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) tb_acc <= '0;
    else tb_acc <= next_tb_acc;
  end

  logic tb_tick;
  logic trig_event;
  assign tb_tick = tb_external ? (tb_sync[1] & ~tb_sync[2]) : int_tick;
  assign trig_event = trig_negative ? (~trg_sync[1] & trg_sync[2]) : (trg_sync[1] & ~trg_sync[2]);

  // ----------------------------------------
  // Channel queue
  // ----------------------------------------
  queue_entry_t queue_mem [QUEUE_DEPTH];
  logic [QAW:0] queue_len;
  logic [QAW-1:0] queue_rd;
  logic q_wr;
  logic q_clear;
  logic conv_issue;
  assign q_wr = wr_en & hit(PADDR, ADDR_QUEUE_DATA) & (state == ST_IDLE) & (queue_len < (QAW+1)'(QUEUE_DEPTH));
  assign q_clear = wr_en & hit(PADDR, ADDR_QUEUE_CTRL) & PWDATA[QCTRL_CLEAR_BIT] & (state == ST_IDLE);

  always_ff @(posedge CLK) begin
    if (q_wr) queue_mem[queue_len[QAW-1:0]] <= queue_entry_t'(PWDATA[QUEUE_ENTRY_W-1:0]);
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      queue_len <= '0;
      queue_rd <= '0;
    end else if (q_clear) begin
      queue_len <= '0;
      queue_rd <= '0;
    end else begin
      if (q_wr) queue_len <= queue_len + 1'b1;
      if (conv_issue) begin
        if ({1'b0, queue_rd} + 1'b1 >= queue_len) queue_rd <= '0;
        else queue_rd <= queue_rd + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Scan sequencing
  // ----------------------------------------
  logic [SCAN_INTERVAL_W-1:0] scan_ticks;
  logic [SAMPLE_INTERVAL_W-1:0] sample_ticks;
  logic [SCAN_SAMPLES_W-1:0] samples_done;
  logic [SCAN_TOTAL_W-1:0] scans_done;
  logic acq_done;
  logic scan_start;
  logic sample_due;
  logic scan_due;
  logic last_scan;
  assign sample_due = (state == ST_SCAN) & tb_tick & (samples_done < scan_samples)
    & (sample_ticks == sample_interval_count - 1'b1);
  assign scan_due = (state == ST_SCAN) & tb_tick & (scan_ticks == scan_interval - 1'b1);
  // Zero scan count runs until acquisition is disabled
  assign last_scan = (scan_total_count != '0) & (scans_done + 1'b1 == scan_total_count);
  // First scan waits for a timebase tick, so no scan conversion starts off the timebase
  assign scan_start = ((state == ST_PEND) & tb_tick) | (scan_due & ~last_scan);
  assign conv_issue = soft_conv | scan_start | sample_due;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state <= ST_IDLE;
      acq_done <= 1'b0;
      scan_ticks <= '0;
      sample_ticks <= '0;
      samples_done <= '0;
      scans_done <= '0;
    end else if (~acq_en) begin
      state <= ST_IDLE;
      acq_done <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (~acq_done) begin
            state <= (trig_mode == TRIG_SOFTWARE) ? ST_PEND : ST_ARMED;
            scans_done <= '0;
          end
        end
        ST_ARMED: begin
          if (trig_event) begin
            state <= ST_PEND;
            scans_done <= '0;
          end
        end
        ST_PEND: begin
          if (tb_tick) state <= ST_SCAN;
        end
        ST_SCAN: begin
          if (tb_tick) begin
            scan_ticks <= scan_ticks + 1'b1;
            sample_ticks <= sample_ticks + 1'b1;
          end
          if (sample_due) begin
            sample_ticks <= '0;
            samples_done <= samples_done + 1'b1;
          end
          if (scan_due) begin
            scans_done <= scans_done + 1'b1;
            if (last_scan) begin
              state <= ST_IDLE;
              acq_done <= 1'b1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
      // First conversion of a scan is issued with the scan start
      if (scan_start) begin
        scan_ticks <= '0;
        sample_ticks <= '0;
        samples_done <= SCAN_SAMPLES_W'(1);
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ADC_START <= 1'b0;
      ADC_SELECT <= '0;
      SIMULTANEOUS_HOLD_STROBE <= 1'b0;
    end else begin
      ADC_START <= conv_issue;
      SIMULTANEOUS_HOLD_STROBE <= scan_start;
      if (conv_issue) ADC_SELECT <= (queue_len == '0) ? queue_entry_t'('0) : queue_mem[queue_rd];
    end
  end

  // ----------------------------------------
  // Conversion watchdog
  // ----------------------------------------
  localparam int CW = $clog2(CONV_CYCLES + 1);
  logic conv_busy;
  logic [CW-1:0] conv_timer;
  logic conv_timeout;
  logic fifo_overrun;
  logic clr_flags;
  assign clr_flags = wr_en & hit(PADDR, ADDR_QUEUE_CTRL) & PWDATA[QCTRL_CLR_FLAGS_BIT];
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      conv_busy <= 1'b0;
      conv_timer <= '0;
    end else if (ADC_START) begin
      conv_busy <= 1'b1;
      conv_timer <= '0;
    end else if (ADC_DONE | (conv_timer == CW'(CONV_CYCLES))) begin
      conv_busy <= 1'b0;
    end else if (conv_busy) begin
      conv_timer <= conv_timer + 1'b1;
    end
  end

  // ----------------------------------------
  // Sample FIFO
  // ----------------------------------------
  logic [SAMPLE_W-1:0] fifo_mem [FIFO_DEPTH];
  logic [FAW-1:0] fifo_wr;
  logic [FAW-1:0] fifo_rd;
  logic [FAW:0] fifo_count;
  logic fifo_empty;
  logic fifo_full;
  logic push;
  logic pop;
  assign fifo_empty = fifo_count == '0;
  assign fifo_full = fifo_count == (FAW+1)'(FIFO_DEPTH);
  assign push = ADC_DONE & ~fifo_full;
  assign pop = rd_en & hit(PADDR, ADDR_SAMPLE_DATA) & ~fifo_empty;

  always_ff @(posedge CLK) begin
    if (push) fifo_mem[fifo_wr] <= ADC_DATA;
  end
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      fifo_wr <= '0;
      fifo_rd <= '0;
      fifo_count <= '0;
    end else begin
      if (push) fifo_wr <= fifo_wr + 1'b1;
      if (pop) fifo_rd <= fifo_rd + 1'b1;
      fifo_count <= fifo_count + (FAW+1)'(push) - (FAW+1)'(pop);
    end
  end

  // Sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      conv_timeout <= 1'b0;
      fifo_overrun <= 1'b0;
    end else begin
      conv_timeout <= (conv_busy & ~ADC_DONE & (conv_timer == CW'(CONV_CYCLES))) | (conv_timeout & ~clr_flags);
      fifo_overrun <= (ADC_DONE & fifo_full) | (fifo_overrun & ~clr_flags);
    end
  end

  // ----------------------------------------
  // Read data, captured in the setup phase
  // ----------------------------------------
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = '0;
    case (PADDR)
      ADDR_SAMPLE_DATA: next_prdata[SAMPLE_W-1:0] = fifo_empty ? '0 : fifo_mem[fifo_rd];
      ADDR_FIFO_COND: begin
        next_prdata[STAT_BUSY_BIT] = state != ST_IDLE;
        next_prdata[STAT_TIMEOUT_BIT] = conv_timeout;
        next_prdata[STAT_OVERRUN_BIT] = fifo_overrun;
        next_prdata[STAT_EMPTY_BIT] = fifo_empty;
        next_prdata[STAT_FULL_BIT] = fifo_full;
      end
      ADDR_TRIG_SETUP: next_prdata[10:0] = trig_setup;
      ADDR_SCAN_INTERVAL: next_prdata[SCAN_INTERVAL_W-1:0] = scan_interval;
      ADDR_SAMPLE_INTERVAL: next_prdata[SAMPLE_INTERVAL_W-1:0] = sample_interval_count;
      ADDR_SCAN_TOTAL: next_prdata[SCAN_TOTAL_W-1:0] = scan_total_count;
      ADDR_SCAN_SAMPLES: next_prdata[SCAN_SAMPLES_W-1:0] = scan_samples;
      ADDR_QUEUE_CTRL: next_prdata[QAW:0] = queue_len;
      default: next_prdata = '0;
    endcase
  end
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) PRDATA <= '0;
    else if (PSEL & ~PENABLE & ~PWRITE) PRDATA <= next_prdata;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  soft_conv_a: assert property (soft_conv |=> ADC_START && ($past(queue_rd) != queue_rd || queue_len <= 1))
    else $error("software convert did not start one conversion");
  soft_zero_a: assert property (wr_en && hit(PADDR, ADDR_TRIG_SETUP) && !PWDATA[TRIG_SOFT_CONV_BIT]
    && state == ST_IDLE && !scan_start |=> !ADC_START)
    else $error("convert issued without bit 10 set");
  empty_flag_a: assert property (PSEL && !PENABLE && !PWRITE && PADDR == ADDR_FIFO_COND
    |=> PRDATA[STAT_EMPTY_BIT] == $past(fifo_count == '0))
    else $error("empty flag disagrees with FIFO level");
  push_now_a: assert property (ADC_DONE && !fifo_full && !pop |=> !fifo_empty && fifo_count == $past(fifo_count) + 1'b1)
    else $error("finished sample not written at once");
  conv_time_a: assert property (conv_busy && conv_timer == CW'(CONV_CYCLES) && !ADC_DONE && !ADC_START
    |=> conv_timeout && !conv_busy)
    else $error("overlong conversion not flagged");
  queue_wrap_a: assert property (conv_issue && {1'b0, queue_rd} + 1'b1 >= queue_len && !q_clear |=> queue_rd == '0)
    else $error("queue did not wrap after last entry");
  queue_cap_a: assert property (queue_len <= (QAW+1)'(QUEUE_DEPTH))
    else $error("queue exceeds capacity");
  sample_gap_a: assert property (sample_due && acq_en |=> ADC_START ##1 !ADC_START)
    else $error("sample interval did not start a conversion");
  hold_scan_a: assert property (SIMULTANEOUS_HOLD_STROBE |-> ADC_START ##1 !SIMULTANEOUS_HOLD_STROBE)
    else $error("hold strobe not paired with first conversion");
  scan_stop_a: assert property (scan_due && last_scan && acq_en |=> state == ST_IDLE && acq_done)
    else $error("acquisition did not stop after last scan");
  tb_select_a: assert property (state == ST_SCAN && !tb_tick && !scan_start |=> $stable(scan_ticks))
    else $error("scan timer moved without a timebase tick");

  scan_run_c: cover property (scan_start ##[1:300] sample_due);
  scan_end_c: cover property (scan_due && last_scan);
  soft_poll_c: cover property (soft_conv ##[1:500] push);
  trig_start_c: cover property (state == ST_ARMED && trig_event);
endmodule
`default_nettype wire

// file: pkg/acq_seq_pkg.sv
// Shared constants and types of the scan acquisition sequencer.
// Assumes an APB master with 32-bit data and byte addresses below 0x100.
package acq_seq_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_SAMPLE_DATA = 8'h24;
  localparam logic [7:0] ADDR_FIFO_COND = 8'h28;
  localparam logic [7:0] ADDR_TRIG_SETUP = 8'h34;
  localparam logic [7:0] ADDR_SCAN_INTERVAL = 8'h40;
  localparam logic [7:0] ADDR_SAMPLE_INTERVAL = 8'h44;
  localparam logic [7:0] ADDR_SCAN_TOTAL = 8'h48;
  localparam logic [7:0] ADDR_SCAN_SAMPLES = 8'h4C;
  localparam logic [7:0] ADDR_QUEUE_DATA = 8'h50;
  localparam logic [7:0] ADDR_QUEUE_CTRL = 8'h54;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int TRIG_SOFT_CONV_BIT = 10;
  localparam int TRIG_ACQ_EN_BIT = 9;
  localparam int TRIG_TIMEBASE_BIT = 5;
  localparam int TRIG_POLARITY_BIT = 4;
  localparam int TRIG_MODE_LSB = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TIMEOUT_BIT = 1;
  localparam int STAT_OVERRUN_BIT = 2;
  localparam int STAT_EMPTY_BIT = 4;
  localparam int STAT_FULL_BIT = 5;
  localparam int QCTRL_CLEAR_BIT = 0;
  localparam int QCTRL_CLR_FLAGS_BIT = 1;
  localparam logic [10:0] TRIG_SETUP_MASK = 11'h23E;
  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int SCAN_INTERVAL_W = 24;
  localparam int SAMPLE_INTERVAL_W = 16;
  localparam int SCAN_TOTAL_W = 24;
  localparam int SCAN_SAMPLES_W = 9;
  localparam int SAMPLE_W = 16;
  localparam int QUEUE_ENTRY_W = 10;
  localparam logic [SCAN_INTERVAL_W-1:0] SCAN_INTERVAL_RESET = 24'h0003C0;
  localparam logic [SAMPLE_INTERVAL_W-1:0] SAMPLE_INTERVAL_RESET = 16'h0060;
  localparam logic [SCAN_TOTAL_W-1:0] SCAN_TOTAL_RESET = 24'h000001;
  localparam logic [SCAN_SAMPLES_W-1:0] SCAN_SAMPLES_RESET = 9'h001;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int INT_TIMEBASE_MHZ = 24;
  localparam int CONV_TIME_NS = 4000;
  localparam int CONV_CYCLES = CONV_TIME_NS * CLK_MHZ / 1000;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {CFG_SINGLE = 2'h0, CFG_DIFF = 2'h1, CFG_USER_CM = 2'h2} input_config_t;
  typedef enum logic [2:0] {
    TRIG_SOFTWARE = 3'h0, TRIG_POST = 3'h1, TRIG_DELAY = 3'h2, TRIG_PRE = 3'h3, TRIG_MIDDLE = 3'h4
  } trig_mode_t;
  typedef struct packed {
    input_config_t user_common_mode_input;
    logic [1:0] gain;
    logic [5:0] channel;
  } queue_entry_t;
endpackage

// file: sim/adc_front_model.sv
// Converter front end model for the sequencer bench.
// Assumes one conversion at a time; the bench sets the latency in CLK cycles.
`timescale 1ns/1ps
`default_nettype none
module adc_front_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Converter request
  input wire logic start,
  input wire acq_seq_pkg::queue_entry_t select,
  input wire logic [9:0] latency,
  // Converter answer
  output logic done,
  output logic [15:0] data
);
  import acq_seq_pkg::*;
  logic busy;
  logic [9:0] count;
  logic [5:0] idx;
  queue_entry_t held;
  // ----------------------------------------
  // Conversion timing
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done <= 1'b0;
      data <= 16'h0000;
      busy <= 1'b0;
      count <= 10'h000;
      idx <= 6'h00;
      held <= '0;
    end else begin
      done <= 1'b0;
      // Data is only valid with done, so it churns otherwise
      data <= ~data;
      if (start) begin
        busy <= 1'b1;
        count <= latency;
        held <= select;
      end else if (busy) begin
        if (count <= 10'h001) begin
          busy <= 1'b0;
          done <= 1'b1;
          data <= {idx, held};
          idx <= idx + 6'h01;
        end else begin
          count <= count - 10'h001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the scan acquisition sequencer.
// Assumes the converter model and a 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import acq_seq_pkg::*;
  logic CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, slv_err;
  logic EXT_TIMEBASE, EXT_TRIGGER, SIMULTANEOUS_HOLD_STROBE, ADC_START, ADC_DONE;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, r;
  logic [15:0] ADC_DATA;
  logic [9:0] latency;
  logic [5:0] exp_idx;
  logic [3:0] tb_div;
  queue_entry_t ADC_SELECT;
  int err_total, tests_run, cyc, n0;
  int starts[$];
  int holds[$];
  logic [9:0] sels[$];
  queue_entry_t ent[$];
  logic [7:0] reg_addr [8] = '{8'h24, 8'h28, 8'h34, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h54};
  logic [31:0] reg_rst [8] = '{32'h0, 32'h10, 32'h0, 32'h3C0, 32'h60, 32'h1, 32'h1, 32'h0};

  scan_acquisition_sequencer #(.FIFO_DEPTH(1024), .QUEUE_DEPTH(16)) dut_u (.CLK(CLK), .RESET(RESET),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .EXT_TIMEBASE(EXT_TIMEBASE), .EXT_TRIGGER(EXT_TRIGGER),
    .SIMULTANEOUS_HOLD_STROBE(SIMULTANEOUS_HOLD_STROBE), .ADC_START(ADC_START),
    .ADC_SELECT(ADC_SELECT), .ADC_DONE(ADC_DONE), .ADC_DATA(ADC_DATA));
  adc_front_model conv_u (.clk(CLK), .reset(RESET), .start(ADC_START), .select(ADC_SELECT),
    .latency(latency), .done(ADC_DONE), .data(ADC_DATA));

  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  // ----------------------------------------
  // External timebase and event recorder
  // ----------------------------------------
  always @(posedge CLK) begin
    tb_div <= (tb_div == 4'h9) ? 4'h0 : tb_div + 4'h1;
    EXT_TIMEBASE <= (tb_div < 4'h5);
    cyc <= cyc + 1;
    if (ADC_START === 1'b1) begin
      starts.push_back(cyc);
      sels.push_back(ADC_SELECT);
    end
    if (SIMULTANEOUS_HOLD_STROBE === 1'b1) holds.push_back(cyc);
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic fail_wait;
    err_total++;
    finish_test();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    if (PREADY !== 1'b1) fail_wait();
    q = PRDATA;
    slv_err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask
  task automatic take(input logic poll, input logic [9:0] sel);
    logic [31:0] q;
    int n;
    n = 0;
    q = 32'h10;
    while (poll && q[STAT_EMPTY_BIT] && n < 2000) begin
      apb(1'b0, ADDR_FIFO_COND, 32'h0, q);
      n++;
    end
    if (n >= 2000) fail_wait();
    apb(1'b0, ADDR_SAMPLE_DATA, 32'h0, q);
    chk("sample", q, {16'h0, exp_idx, sel});
    exp_idx++;
  endtask
  task automatic wait_starts(input int k);
    int n;
    n = 0;
    while (starts.size() < k && n < 3000) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 3000) fail_wait();
  endtask
  task automatic qload(input int k);
    queue_entry_t e;
    wr(ADDR_QUEUE_CTRL, 32'h1);
    ent.delete();
    for (int i = 0; i < k; i++) begin
      e = {input_config_t'(i % 3), 2'($urandom), 6'($urandom)};
      ent.push_back(e);
      wr(ADDR_QUEUE_DATA, {22'h0, e});
    end
  endtask
  // ----------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------
  initial begin
    repeat (100000) @(posedge CLK);
    fail_wait();
  end
  initial begin
    {PSEL, PENABLE, PWRITE, EXT_TRIGGER, EXT_TIMEBASE} = 5'h00;
    {PADDR, PWDATA, tb_div, exp_idx, cyc, err_total, tests_run} = '0;
    RESET = 1'b1;
    latency = 10'd400;
    void'($urandom(32'hB772));
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, reg_addr[i], 32'h0, r);
      chk("reset_value", r, reg_rst[i]);
    end
    apb(1'b0, 8'h30, 32'h0, r);
    chk("unmapped_err", slv_err, 32'h1);
    qload(17);
    apb(1'b0, ADDR_QUEUE_CTRL, 32'h0, r);
    chk("queue_len", r, 32'd16);
    qload(3);
    for (int i = 0; i < 4; i++) begin
      n0 = starts.size();
      wr(ADDR_TRIG_SETUP, 32'h400);
      wr(ADDR_TRIG_SETUP, 32'h0);
      chk("one_start", starts.size() - n0, 32'd1);
      chk("soft_select", sels[n0], ent[i % 3]);
      if (i == 1) begin
        repeat (500) @(posedge CLK);
        take(1'b0, ent[i % 3]);
      end else take(1'b1, ent[i % 3]);
    end
    apb(1'b0, ADDR_FIFO_COND, 32'h0, r);
    chk("status_idle", r, 32'h10);
    latency <= 10'd600;
    wr(ADDR_TRIG_SETUP, 32'h400);
    repeat (700) @(posedge CLK);
    apb(1'b0, ADDR_FIFO_COND, 32'h0, r);
    chk("conv_timeout", r, 32'h2);
    take(1'b0, ent[1]);
    wr(ADDR_QUEUE_CTRL, 32'h2);
    apb(1'b0, ADDR_FIFO_COND, 32'h0, r);
    chk("flags_cleared", r, 32'h10);
    latency <= 10'd20;
    qload(2);
    wr(ADDR_SAMPLE_INTERVAL, 32'd3);
    wr(ADDR_SCAN_INTERVAL, 32'd10);
    wr(ADDR_SCAN_TOTAL, 32'd2);
    wr(ADDR_SCAN_SAMPLES, 32'd3);
    starts.delete();
    sels.delete();
    wr(ADDR_TRIG_SETUP, 32'h220);
    wait_starts(6);
    repeat (300) @(posedge CLK);
    chk("scan_starts", starts.size(), 32'd6);
    chk("holds", holds.size(), 32'd2);
    chk("hold_first", holds[0], starts[0]);
    chk("hold_second", holds[1], starts[3]);
    chk("sample_gap", starts[2] - starts[1], 32'd30);
    chk("scan_gap", starts[3] - starts[0], 32'd100);
    wr(ADDR_TRIG_SETUP, 32'h0);
    for (int i = 0; i < 6; i++) begin
      chk("scan_select", sels[i], ent[i % 2]);
      take(1'b1, ent[i % 2]);
    end
    wr(ADDR_QUEUE_CTRL, 32'h1);
    wr(ADDR_SAMPLE_INTERVAL, 32'd96);
    wr(ADDR_SCAN_INTERVAL, 32'd192);
    wr(ADDR_SCAN_TOTAL, 32'd1);
    wr(ADDR_SCAN_SAMPLES, 32'd2);
    for (int m = 0; m < 5; m++) begin
      starts.delete();
      wr(ADDR_TRIG_SETUP, 32'h200 | (m << TRIG_MODE_LSB) | ((m == 4) ? 32'h10 : 32'h0));
      if (m != 0) begin
        repeat (20) @(posedge CLK);
        chk("waits_trigger", starts.size(), 32'd0);
        EXT_TRIGGER <= 1'b1;
        repeat ((m == 4) ? 20 : 4) @(posedge CLK);
        // Last mode runs on the falling edge, so the rise must not start it
        if (m == 4) chk("rise_ignored", starts.size(), 32'd0);
        EXT_TRIGGER <= 1'b0;
      end
      wait_starts(2);
      chk("internal_gap", (starts[1] - starts[0]) inside {[499:501]}, 32'd1);
      take(1'b1, 10'h000);
      take(1'b1, 10'h000);
      wr(ADDR_TRIG_SETUP, 32'h0);
    end
    finish_test();
  end
endmodule
`default_nettype wire
